// >>> hdl/ecsg_pkg.sv
package ecsg_pkg;
   // Register offsets on the serial register port
   localparam logic [6:0] ADDR_SYS_EN   = 7'h04;
   localparam logic [6:0] ADDR_GLOBAL   = 7'h60;
   localparam logic [6:0] ADDR_SYS_FLG  = 7'h61;
   localparam logic [6:0] ADDR_SUP_FLG  = 7'h62;
   localparam logic [6:0] ADDR_TRX_FLG  = 7'h63;
   localparam logic [6:0] ADDR_WAKE_FLG = 7'h64;

   // System flag positions
   localparam int POWER_UP_BIT     = 4;
   localparam int OVERHEAT_BIT     = 2;
   localparam int SERIAL_FAULT_BIT = 1;
   localparam int WATCHDOG_BIT     = 0;
   // Supply flag positions
   localparam int SENSOR_OVER_BIT  = 2;
   localparam int SENSOR_UNDER_BIT = 1;
   localparam int MAIN_UNDER_BIT   = 0;
   // Transceiver flag positions
   localparam int SILENCE_BIT      = 4;
   localparam int TRX_FAULT_BIT    = 1;
   localparam int BUS_WAKE_BIT     = 0;
   // Wake pin flag positions
   localparam int RISING_BIT       = 1;
   localparam int FALLING_BIT      = 0;
   // Summary bit positions
   localparam int WAKE_GRP_BIT     = 3;
   localparam int TRX_GRP_BIT      = 2;
   localparam int SUP_GRP_BIT      = 1;
   localparam int SYS_GRP_BIT      = 0;

   // Implemented bits; all others read zero
   localparam logic [7:0] SYS_FLG_MASK  = 8'h17;
   localparam logic [7:0] SUP_FLG_MASK  = 8'h07;
   localparam logic [7:0] TRX_FLG_MASK  = 8'h13;
   localparam logic [7:0] WAKE_FLG_MASK = 8'h03;
   localparam logic [7:0] SYS_EN_MASK   = 8'h06;
   localparam logic [7:0] GLOBAL_MASK   = 8'h0F;

   // Values after reset
   localparam logic [7:0] FLAGS_RESET   = 8'h00;
   localparam logic [7:0] SYS_EN_RESET  = 8'h00;
   localparam logic [7:0] RDATA_RESET   = 8'h00;

   // Command and mode codes
   localparam logic [2:0] MC_SLEEP      = 3'h1;
   localparam logic [1:0] TRX_MODE_UV   = 2'h1;

   // Sleep guard states
   typedef enum logic [0:0] {ST_RUN, ST_SLEEP} ecsg_state_t;
endpackage : ecsg_pkg

// >>> hdl/ecsg_edge_detect.sv
`timescale 1ns/1ps
// Rising and falling edge pulses of a synchronous level input
module ecsg_edge_detect (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   // Level in, pulses out
   input  wire logic level_i,
   output logic      rise_o,
   output logic      fall_o
);
   logic prev;

   // Previous sample; reset low so a high pin at release reads as a rise
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev <= 1'b0;
      end else begin
         prev <= level_i;
      end
   end

   // Combinational pulses, registered by the flag logic downstream
   assign rise_o = level_i & ~prev;
   assign fall_o = ~level_i & prev;
endmodule : ecsg_edge_detect

// >>> hdl/ecsg_event_capture.sv
`timescale 1ns/1ps
// Overview of operation
// - Sleep needs a regular wake source enabled
// - No wake source on sleep request: reset
// - Sleep command with pending flag: reset
// - Sleep disabled: command sets serial fault only
// - Sleep-disable bit comes from non-volatile store
// - Flags clear by writing one only
// - Summary at 60h, groups in bits 3:0
// - Summary bit set while its group nonzero
// - System flags: power-up, overheat, serial, watchdog
// - Power-up and overheat flag sources
// - Supply flags: sensor over/under, main under
// - Transceiver bit 4 flags bus silence
// - Transceiver bit 1 flags fault conditions
// - Transceiver bit 0 flags offline bus wake
// - Wake pin rising bit 1, falling bit 0
// - System capture enable at 04h, bits 2:1
// - Flags set only when capture enabled, except power-up and watchdog
// - Wake-ups regular, failures diagnostic
// - Offline with regulator on and a flag pending: receive pin low
module ecsg_event_capture (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // Register port from the serial front end
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [6:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   // Mode command from the serial front end
   input  wire logic       mode_cmd_valid_i,
   input  wire logic [2:0] operating_state_command_i,
   // System events, one-cycle pulses
   input  wire logic       power_up_event_i,
   input  wire logic       overheat_event_i,
   input  wire logic       serial_fault_event_i,
   input  wire logic       watchdog_fault_event_i,
   // Supply events, one-cycle pulses
   input  wire logic       sensor_supply_over_event_i,
   input  wire logic       sensor_supply_under_event_i,
   input  wire logic       main_regulator_under_event_i,
   // Transceiver events and state
   input  wire logic       bus_silence_event_i,
   input  wire logic       trx_undervoltage_off_event_i,
   input  wire logic       txd_clamped_event_i,
   input  wire logic       bus_wakeup_event_i,
   input  wire logic [1:0] transceiver_mode_field_i,
   input  wire logic       trx_offline_i,
   input  wire logic       main_regulator_on_i,
   // Wake pin level
   input  wire logic       wake_pin_i,
   // Capture enables held outside this block
   input  wire logic [2:0] supply_capture_en_i,
   input  wire logic [2:0] trx_capture_en_i,
   input  wire logic [1:0] wake_capture_en_i,
   // Non-volatile configuration
   input  wire logic       sleep_disable_bit_i,
   // Outcomes
   output logic            enter_sleep_o,
   output logic            system_reset_o,
   output logic            sleep_active_o,
   output logic            rxd_low_o
);
   import ecsg_pkg::*;

   logic [7:0]  sys_flags;
   logic [7:0]  sup_flags;
   logic [7:0]  trx_flags;
   logic [7:0]  wake_flags;
   logic [7:0]  sys_en;
   logic [7:0]  global_sum;
   logic [7:0]  sys_set, sup_set, trx_set, wake_set;
   logic        wake_rise, wake_fall;
   logic        regular_wake_en;
   logic        any_pending;
   logic        sleep_cmd;
   logic        guard_serial_port_fault_flag;
   logic        guard_reset;
   logic        guard_sleep;
   logic        wake_from_sleep;
   ecsg_state_t state;

   // Clear mask: ones written to a given address
   function automatic logic [7:0] clr_mask(input logic [6:0] a);
      clr_mask = (reg_wr_i && reg_addr_i == a) ? reg_wdata_i : 8'h00;
   endfunction : clr_mask

   // Set wins over clear so an event in the clearing cycle survives
   function automatic logic [7:0] next_flags(input logic [7:0] cur,
                                             input logic [7:0] set,
                                             input logic [7:0] clr,
                                             input logic [7:0] msk);
      next_flags = ((cur & ~clr) | set) & msk;
   endfunction : next_flags

   ecsg_edge_detect u_wake_edge (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .level_i (wake_pin_i),
      .rise_o  (wake_rise),
      .fall_o  (wake_fall)
   );

   // Sleep command decode and guard outcome
   assign sleep_cmd = mode_cmd_valid_i && state == ST_RUN
                      && operating_state_command_i == MC_SLEEP;
   assign regular_wake_en = trx_capture_en_i[BUS_WAKE_BIT]
                            | (|wake_capture_en_i);
   assign any_pending = |global_sum;
   // Non-volatile bit arrives as a level held outside
   assign guard_serial_port_fault_flag  = sleep_cmd && sleep_disable_bit_i;
   assign guard_reset = sleep_cmd && !sleep_disable_bit_i
                        && (!regular_wake_en
                            || any_pending);
   assign guard_sleep = sleep_cmd && !sleep_disable_bit_i
                        && regular_wake_en && !any_pending;

   // Any captured regular event leaves sleep through reset
   assign wake_from_sleep = state == ST_SLEEP
                            && (|wake_set || trx_set[BUS_WAKE_BIT]);

   // System set terms; overheat and serial fault not captured asleep
   always_comb begin
      sys_set = 8'h00;
      sys_set[POWER_UP_BIT]     = power_up_event_i;
      sys_set[WATCHDOG_BIT]     = watchdog_fault_event_i;
      sys_set[OVERHEAT_BIT]     = overheat_event_i
                                  && sys_en[OVERHEAT_BIT]
                                  && state == ST_RUN;
      sys_set[SERIAL_FAULT_BIT] = (serial_fault_event_i || guard_serial_port_fault_flag)
                                  && sys_en[SERIAL_FAULT_BIT]
                                  && state == ST_RUN;
   end

   // Supply set terms
   always_comb begin
      sup_set = 8'h00;
      sup_set[SENSOR_OVER_BIT]  = sensor_supply_over_event_i
                                  && supply_capture_en_i[2];
      sup_set[SENSOR_UNDER_BIT] = sensor_supply_under_event_i
                                  && supply_capture_en_i[1];
      sup_set[MAIN_UNDER_BIT]   = main_regulator_under_event_i
                                  && supply_capture_en_i[0];
   end

   // Transceiver set terms
   always_comb begin
      trx_set = 8'h00;
      trx_set[SILENCE_BIT]   = bus_silence_event_i
                               && trx_capture_en_i[2];
      trx_set[TRX_FAULT_BIT] = trx_capture_en_i[1]
         && ((transceiver_mode_field_i == TRX_MODE_UV
              && trx_undervoltage_off_event_i)
             || txd_clamped_event_i);
      trx_set[BUS_WAKE_BIT]  = bus_wakeup_event_i && trx_offline_i
                               && trx_capture_en_i[0];
   end

   // Wake pin set terms
   always_comb begin
      wake_set = 8'h00;
      wake_set[RISING_BIT]  = wake_rise && wake_capture_en_i[1];
      wake_set[FALLING_BIT] = wake_fall && wake_capture_en_i[0];
   end

   // Event flags, write-one-to-clear
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sys_flags  <= FLAGS_RESET;
         sup_flags  <= FLAGS_RESET;
         trx_flags  <= FLAGS_RESET;
         wake_flags <= FLAGS_RESET;
      end else begin
         sys_flags  <= next_flags(sys_flags, sys_set,
                          clr_mask(ADDR_SYS_FLG), SYS_FLG_MASK);
         sup_flags  <= next_flags(sup_flags, sup_set,
                          clr_mask(ADDR_SUP_FLG), SUP_FLG_MASK);
         trx_flags  <= next_flags(trx_flags, trx_set,
                          clr_mask(ADDR_TRX_FLG), TRX_FLG_MASK);
         wake_flags <= next_flags(wake_flags, wake_set,
                          clr_mask(ADDR_WAKE_FLG), WAKE_FLG_MASK);
      end
   end

   // System capture enable register
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sys_en <= SYS_EN_RESET;
      end else if (reg_wr_i && reg_addr_i == ADDR_SYS_EN) begin
         sys_en <= reg_wdata_i & SYS_EN_MASK;
      end
   end

   // Pending summary per group
   always_comb begin
      global_sum = 8'h00;
      global_sum[WAKE_GRP_BIT] = |wake_flags;
      global_sum[TRX_GRP_BIT]  = |trx_flags;
      global_sum[SUP_GRP_BIT]  = |sup_flags;
      global_sum[SYS_GRP_BIT]  = |sys_flags;
   end

   // Read data, one cycle after the read strobe
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= RDATA_RESET;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            ADDR_SYS_EN:   reg_rdata_o <= sys_en;
            ADDR_GLOBAL:   reg_rdata_o <= global_sum & GLOBAL_MASK;
            ADDR_SYS_FLG:  reg_rdata_o <= sys_flags;
            ADDR_SUP_FLG:  reg_rdata_o <= sup_flags;
            ADDR_TRX_FLG:  reg_rdata_o <= trx_flags;
            ADDR_WAKE_FLG: reg_rdata_o <= wake_flags;
            default:       reg_rdata_o <= RDATA_RESET;
         endcase
      end
   end

   // Sleep guard state
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= ST_RUN;
      end else begin
         case (state)
            ST_RUN: begin
               if (guard_sleep) begin
                  state <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               if (wake_from_sleep) begin
                  state <= ST_RUN;
               end
            end
            default: state <= ST_RUN;
         endcase
      end
   end

   // Outcome pulses and sleep-active level; a refused sleep becomes a system reset
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         enter_sleep_o  <= 1'b0;
         system_reset_o <= 1'b0;
         sleep_active_o <= 1'b0;
      end else begin
         enter_sleep_o  <= guard_sleep;
         system_reset_o <= guard_reset || wake_from_sleep;
         sleep_active_o <= guard_sleep
                           || (state == ST_SLEEP && !wake_from_sleep);
      end
   end

   // Receive pin pulled low to alert the host while offline
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rxd_low_o <= 1'b0;
      end else begin
         rxd_low_o <= trx_offline_i && main_regulator_on_i
                      && any_pending;
      end
   end

   // Assertions
   property p_refuse_no_wake;
      @(posedge clk_i) disable iff (!rst_b_i)
      sleep_cmd && !sleep_disable_bit_i && !regular_wake_en
      |=> system_reset_o && !enter_sleep_o;
   endproperty
   a_refuse_no_wake: assert property (p_refuse_no_wake)
      else $error("sleep without wake source did not reset");

   property p_sleep_needs_wake;
      @(posedge clk_i) disable iff (!rst_b_i)
      enter_sleep_o |-> $past(regular_wake_en);
   endproperty
   a_sleep_needs_wake: assert property (p_sleep_needs_wake)
      else $error("sleep entered with no wake source");

   property p_pending_reset;
      @(posedge clk_i) disable iff (!rst_b_i)
      sleep_cmd && !sleep_disable_bit_i && any_pending
      |=> system_reset_o && state == ST_RUN;
   endproperty
   a_pending_reset: assert property (p_pending_reset)
      else $error("sleep with pending flag did not reset");

   property p_disabled_sleep;
      @(posedge clk_i) disable iff (!rst_b_i)
      sleep_cmd && sleep_disable_bit_i && sys_en[SERIAL_FAULT_BIT]
      |=> sys_flags[SERIAL_FAULT_BIT] && state == ST_RUN
          && !system_reset_o && !enter_sleep_o;
   endproperty
   a_disabled_sleep: assert property (p_disabled_sleep)
      else $error("disabled sleep not turned into serial fault");

   property p_zero_write_keeps;
      @(posedge clk_i) disable iff (!rst_b_i)
      reg_wr_i && reg_addr_i == ADDR_WAKE_FLG
      && !reg_wdata_i[RISING_BIT] && wake_flags[RISING_BIT]
      |=> wake_flags[RISING_BIT];
   endproperty
   a_zero_write_keeps: assert property (p_zero_write_keeps)
      else $error("writing zero cleared a flag");

   property p_one_write_clears;
      @(posedge clk_i) disable iff (!rst_b_i)
      reg_wr_i && reg_addr_i == ADDR_SUP_FLG
      && reg_wdata_i[MAIN_UNDER_BIT] && !sup_set[MAIN_UNDER_BIT]
      |=> !sup_flags[MAIN_UNDER_BIT];
   endproperty
   a_one_write_clears: assert property (p_one_write_clears)
      else $error("writing one did not clear a flag");

   property p_summary_read;
      @(posedge clk_i) disable iff (!rst_b_i)
      reg_rd_i && reg_addr_i == ADDR_GLOBAL
      |=> reg_rdata_o == {4'h0, |$past(wake_flags), |$past(trx_flags),
                          |$past(sup_flags), |$past(sys_flags)};
   endproperty
   a_summary_read: assert property (p_summary_read)
      else $error("summary read wrong");

   property p_wake_edge;
      @(posedge clk_i) disable iff (!rst_b_i)
      $rose(wake_pin_i) && wake_capture_en_i[1]
      |=> wake_flags[RISING_BIT] && global_sum[WAKE_GRP_BIT];
   endproperty
   a_wake_edge: assert property (p_wake_edge)
      else $error("rising wake edge not captured");

   property p_disabled_capture;
      @(posedge clk_i) disable iff (!rst_b_i)
      !sys_flags[OVERHEAT_BIT] && !sys_en[OVERHEAT_BIT]
      |=> !sys_flags[OVERHEAT_BIT];
   endproperty
   a_disabled_capture: assert property (p_disabled_capture)
      else $error("overheat captured while disabled");

   property p_rxd_alert;
      @(posedge clk_i) disable iff (!rst_b_i)
      trx_offline_i && main_regulator_on_i && any_pending |=> rxd_low_o;
   endproperty
   a_rxd_alert: assert property (p_rxd_alert)
      else $error("receive pin not pulled low on pending event");

   c_sleep: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      enter_sleep_o ##[1:20] system_reset_o);
   c_refused: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      guard_reset && any_pending);
   c_serial_port_fault_flag: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      guard_serial_port_fault_flag);
endmodule : ecsg_event_capture

// >>> testbench/ecsg_host_model.sv
`timescale 1ns/1ps
// Host on the register port: strobed writes, reads and mode commands
module ecsg_host_model (
   // Clock
   input  wire logic       clk_i,
   // Register port toward the block
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   output logic      [6:0] reg_addr_o,
   output logic      [7:0] reg_wdata_o,
   input  wire logic [7:0] reg_rdata_i,
   // Mode command toward the block
   output logic            cmd_valid_o,
   output logic      [2:0] cmd_code_o
);
   // Idle port; address parked on an unmapped place
   initial begin
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_addr_o  = 7'h7F;
      reg_wdata_o = 8'h00;
      cmd_valid_o = 1'b0;
      cmd_code_o  = 3'h0;
   end

   // Write; only ones clear flags, so clear what was seen set
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_wr_o    <= 1'b1;
      reg_addr_o  <= a;
      reg_wdata_o <= d;
      @(posedge clk_i);
      reg_wr_o    <= 1'b0;
      reg_wdata_o <= ~d; // Stale data never looks valid
      #1;
   endtask : wr

   // Read; data is registered one edge after the strobe
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_rd_o   <= 1'b1;
      reg_addr_o <= a;
      @(posedge clk_i);
      reg_rd_o   <= 1'b0;
      #1;
      d = reg_rdata_i;
   endtask : rd

   // Mode command strobe, result visible after the taking edge
   task automatic cmd(input logic [2:0] c);
      @(posedge clk_i);
      cmd_valid_o <= 1'b1;
      cmd_code_o  <= c;
      @(posedge clk_i);
      cmd_valid_o <= 1'b0;
      cmd_code_o  <= ~c;
      #1;
   endtask : cmd
endmodule : ecsg_host_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import ecsg_pkg::*;
   logic        clk, rst_b, wr, rd, cv, wake, toff, ron, sdis;
   logic [6:0]  addr;
   logic [7:0]  wd, rdat, d;
   logic [2:0]  code, sen, ten;
   logic [1:0]  tmode, wen;
   logic [10:0] ev;
   logic        es, sr, sa, rxl;
   int          fails, checks_done, n;
   logic [6:0]  regs [7];

   // Clock and static levels at time zero
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      ev = '0;
      {wake, toff, ron, sdis} = 4'h0;
      {sen, ten, tmode, wen} = 10'h000;
   end
   always #25 clk = ~clk;

   ecsg_host_model i_ecsg_host_model (
      .clk_i(clk), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
      .reg_wdata_o(wd), .reg_rdata_i(rdat), .cmd_valid_o(cv),
      .cmd_code_o(code));

   ecsg_event_capture i_ecsg_event_capture (
      .clk_i(clk), .rst_b_i(rst_b), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
      .mode_cmd_valid_i(cv), .operating_state_command_i(code),
      .power_up_event_i(ev[0]), .overheat_event_i(ev[1]),
      .serial_fault_event_i(ev[2]), .watchdog_fault_event_i(ev[3]),
      .sensor_supply_over_event_i(ev[4]),
      .sensor_supply_under_event_i(ev[5]),
      .main_regulator_under_event_i(ev[6]),
      .bus_silence_event_i(ev[7]), .trx_undervoltage_off_event_i(ev[8]),
      .txd_clamped_event_i(ev[9]), .bus_wakeup_event_i(ev[10]),
      .transceiver_mode_field_i(tmode), .trx_offline_i(toff),
      .main_regulator_on_i(ron), .wake_pin_i(wake),
      .supply_capture_en_i(sen), .trx_capture_en_i(ten),
      .wake_capture_en_i(wen), .sleep_disable_bit_i(sdis),
      .enter_sleep_o(es), .system_reset_o(sr), .sleep_active_o(sa),
      .rxd_low_o(rxl));

   // Compare and count
   task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic rd_chk(logic [6:0] a, logic [7:0] e);
      i_ecsg_host_model.rd(a, d);
      chk($sformatf("reg %h", a), e, d);
   endtask : rd_chk

   // One-cycle event pulses; flags land on the second edge
   task automatic pulse(logic [10:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= '0;
      #1;
   endtask : pulse

   // Clear every group so the sleep checks start clean
   task automatic clr_all();
      for (int k = 2; k < 6; k++)
         i_ecsg_host_model.wr(regs[k], 8'hFF);
   endtask : clr_all

   task automatic sleep_chk(logic e_s, logic e_r);
      i_ecsg_host_model.cmd(MC_SLEEP);
      chk("enter_sleep", {7'h00, e_s}, {7'h00, es});
      chk("system_reset", {7'h00, e_r}, {7'h00, sr});
   endtask : sleep_chk

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test

   // Hang guard, far beyond the roughly 150 cycles of the run
   initial begin
      #1000000;
      fails++;
      end_of_test();
   end

   initial begin
      regs = '{ADDR_SYS_EN, ADDR_GLOBAL, ADDR_SYS_FLG, ADDR_SUP_FLG,
               ADDR_TRX_FLG, ADDR_WAKE_FLG, 7'h05};
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      // All places zero after reset, unmapped one too
      for (int k = 0; k < 7; k++)
         rd_chk(regs[k], FLAGS_RESET);
      // Overheat and serial fault need their enables
      pulse(11'h00F);
      rd_chk(ADDR_SYS_FLG, 8'h11);
      rd_chk(ADDR_GLOBAL, 8'h01);
      i_ecsg_host_model.wr(ADDR_SYS_EN, 8'hFF);
      rd_chk(ADDR_SYS_EN, SYS_EN_MASK);
      pulse(11'h006);
      rd_chk(ADDR_SYS_FLG, SYS_FLG_MASK);
      i_ecsg_host_model.wr(ADDR_SYS_FLG, 8'h00);
      rd_chk(ADDR_SYS_FLG, SYS_FLG_MASK);
      // Power-up bit written zero, so it survives the clear
      i_ecsg_host_model.wr(ADDR_SYS_FLG, 8'hE9);
      rd_chk(ADDR_SYS_FLG, 8'h16);
      clr_all();
      // Supply group
      @(posedge clk);
      sen <= 3'h7;
      pulse(11'h070);
      rd_chk(ADDR_SUP_FLG, SUP_FLG_MASK);
      rd_chk(ADDR_GLOBAL, 8'h02);
      // Transceiver group, offline with regulator on
      @(posedge clk);
      {ten, tmode, toff, ron} <= {3'h7, TRX_MODE_UV, 2'h3};
      pulse(11'h580);
      rd_chk(ADDR_TRX_FLG, TRX_FLG_MASK);
      chk("rxd_low", 8'h01, {7'h00, rxl});
      clr_all();
      repeat (2) @(posedge clk);
      #1;
      chk("rxd_low", 8'h00, {7'h00, rxl});
      // Undervoltage off counts only in mode 01; wake only offline
      @(posedge clk);
      {tmode, toff} <= 3'h0;
      pulse(11'h500);
      rd_chk(ADDR_TRX_FLG, 8'h00);
      pulse(11'h200);
      rd_chk(ADDR_TRX_FLG, 8'h02);
      // Wake pin edges
      @(posedge clk);
      wen <= 2'h3;
      wake <= 1'b1;
      repeat (3) @(posedge clk);
      wake <= 1'b0;
      repeat (3) @(posedge clk);
      rd_chk(ADDR_WAKE_FLG, WAKE_FLG_MASK);
      rd_chk(ADDR_GLOBAL, 8'h0C);
      clr_all();
      rd_chk(ADDR_GLOBAL, 8'h00);
      // No regular wake source: reset instead of sleep
      @(posedge clk);
      {ten, wen} <= {3'h6, 2'h0};
      sleep_chk(1'b0, 1'b1);
      // Pending diagnostic flag blocks sleep
      @(posedge clk);
      {ten, wen} <= {3'h7, 2'h2};
      pulse(11'h008);
      sleep_chk(1'b0, 1'b1);
      clr_all();
      // Sleep disabled: serial fault only
      @(posedge clk);
      sdis <= 1'b1;
      sleep_chk(1'b0, 1'b0);
      rd_chk(ADDR_SYS_FLG, 8'h02);
      clr_all();
      @(posedge clk);
      sdis <= 1'b0;
      // Codes other than sleep leave the guard alone
      i_ecsg_host_model.cmd(3'h2);
      chk("other code", 8'h00, {6'h00, es, sr});
      // Accepted sleep, then a rising wake edge ends it
      sleep_chk(1'b1, 1'b0);
      chk("sleep_active", 8'h01, {7'h00, sa});
      @(posedge clk);
      wake <= 1'b1;
      n = 0;
      while (sr !== 1'b1 && n < 10) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("wake reset", 8'h01, {7'h00, sr});
      chk("sleep_active", 8'h00, {7'h00, sa});
      // Mid-run reset drops flags; pin low so no edge at release
      @(posedge clk);
      {rst_b, wake} <= 2'h0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd_chk(ADDR_WAKE_FLG, FLAGS_RESET);
      rd_chk(ADDR_SYS_EN, SYS_EN_RESET);
      end_of_test();
   end
endmodule : tb_top
